// *** include/ppmr_pkg.sv ***
// constants for the profile pin modulation router
// assumes both ends import nothing and use ppmr_pkg::name; the bench imports nothing and uses literals
package ppmr_pkg;
	// modulation level codes
	localparam logic [1:0] LVL_TWO     = 2'h0;
	localparam logic [1:0] LVL_FOUR    = 2'h1;
	localparam logic [1:0] LVL_EIGHT   = 2'h2;
	localparam logic [1:0] LVL_SIXTEEN = 2'h3;
	// ramp assignment codes
	localparam logic [1:0] RAMP_OFF    = 2'h0;
	localparam logic [1:0] RAMP_P23    = 2'h1;
	localparam logic [1:0] RAMP_P3     = 2'h2;
	localparam logic [1:0] RAMP_SER    = 2'h3;
	// sweep target codes
	localparam logic [1:0] TGT_NONE    = 2'h0;
	localparam logic [1:0] TGT_AMPL    = 2'h1;
	localparam logic [1:0] TGT_FREQ    = 2'h2;
	localparam logic [1:0] TGT_PHASE   = 2'h3;
	// pin map select codes
	localparam logic [2:0] PMAP_DUAL   = 3'h5;
	localparam logic [1:0] PMAP_CH0LO  = 2'h2;
	localparam logic [1:0] PMAP_CH1LO  = 2'h3;
	// channel word register addresses used by sweep
	localparam logic [7:0] ADDR_FREQ0  = 8'h04;
	localparam logic [7:0] ADDR_PHASE0 = 8'h05;
	localparam logic [7:0] ADDR_AMPL0  = 8'h06;
	localparam logic [7:0] ADDR_WORD1  = 8'h0a;
	// sweep word widths and channel word index values
	localparam int FREQ_W  = 32;
	localparam int PHASE_W = 14;
	localparam int AMPL_W  = 10;
	localparam logic [3:0] WORD_ZERO   = 4'h0;
	localparam logic [3:0] WORD_ONE    = 4'h1;
endpackage

// *** include/ppmr_link_if.sv ***
// pins between host controller and synthesizer profile router
// assumes one core clock shared by both ends
interface ppmr_link_if;
	logic [3:0] profileIn;  // profile_input_0..3, bit n is input n
	logic [3:0] serialOut;  // host drive of serial lines 0..3
	logic [3:0] serialOe;   // host enable on serial lines
	logic       dataWide;   // host uses multi-line formats
	modport host (output profileIn, output serialOut, output serialOe, output dataWide);
	modport device (input profileIn, input serialOut, input serialOe, input dataWide);
endinterface

// *** hdl/ppmr_sync_edge.sv ***
// registers one input and reports its edges
// assumes inputs are already synchronous to core_clk
module ppmr_sync_edge (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic d,
	output logic      q,
	output logic      rise,
	output logic      fall
);
	logic prev_reg;
	// sample then compare against the previous sample
	always_ff @(posedge core_clk) begin
		if (reset) begin
			q        <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			q        <= d;
			prev_reg <= q;
		end
	end
	assign rise = q & ~prev_reg;
	assign fall = ~q & prev_reg;
endmodule

// *** hdl/ppmr_device.sv ***
// device end: routes profile and serial lines to channel word, ramp and sweep controls
// assumes host end keeps its own obligations on the shared pins
module ppmr_device (
	input  wire logic        core_clk,
	input  wire logic        reset,
	ppmr_link_if.device      link,
	input  wire logic [2:0]  pinMapSelect,
	input  wire logic [1:0]  modLevel,
	input  wire logic [1:0]  rampAssign,
	input  wire logic [1:0]  sweepTargetSelect0,
	input  wire logic [1:0]  sweepTargetSelect1,
	input  wire logic        sweepEnable0,
	input  wire logic        sweepEnable1,
	input  wire logic [31:0] sweepEndRaw,
	output logic [3:0]       wordIndex0,
	output logic [3:0]       wordIndex1,
	output logic             rampActive0,
	output logic             rampActive1,
	output logic             rampDown0,
	output logic             rampDown1,
	output logic             sweepUp0,
	output logic             sweepUp1,
	output logic             sweepDown0,
	output logic             sweepDown1,
	output logic [7:0]       sweepStartAddr0,
	output logic [7:0]       sweepStartAddr1,
	output logic [7:0]       sweepEndAddr,
	output logic [31:0]      sweepEndWord0,
	output logic [31:0]      sweepEndWord1,
	output logic             configError
);
	logic [3:0] pinQ;
	logic [3:0] pinRise;
	logic [3:0] pinFall;
	logic [3:0] serQ;
	logic [3:0] serLine;
	logic [3:0] idx0_next;
	logic [3:0] idx1_next;
	logic       ra0_next;
	logic       ra1_next;
	logic       rd0_next;
	logic       rd1_next;
	logic       err_next;
	logic       sweepAny;

	// only lines the host actually drives count as high
	assign serLine = link.serialOut & link.serialOe;

	// one sampler per profile input and serial line
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gSample
			ppmr_sync_edge uPin (
				.core_clk (core_clk),
				.reset    (reset),
				.d        (link.profileIn[g]),
				.q        (pinQ[g]),
				.rise     (pinRise[g]),
				.fall     (pinFall[g])
			);
			ppmr_sync_edge uSer (
				.core_clk (core_clk),
				.reset    (reset),
				.d        (serLine[g]),
				.q        (serQ[g]),
				.rise     (),
				.fall     ()
			);
		end
	endgenerate

	assign sweepAny = sweepEnable0 | sweepEnable1;

	// routing decode; undocumented settings fall back to word zero, no ramp, except sweep off level two and wide serial ramps, which stay routed
	always_comb begin
		idx0_next = ppmr_pkg::WORD_ZERO;
		idx1_next = ppmr_pkg::WORD_ZERO;
		ra0_next  = 1'b0;
		ra1_next  = 1'b0;
		rd0_next  = 1'b0;
		rd1_next  = 1'b0;
		err_next  = 1'b0;
		if (sweepAny) begin
			// sweep owns inputs 0 and 1, word index stays at zero
			if (modLevel != ppmr_pkg::LVL_TWO)
				err_next = 1'b1;
			unique case (rampAssign)
				ppmr_pkg::RAMP_P23: begin
					ra0_next = 1'b1;
					ra1_next = 1'b1;
					rd0_next = pinQ[2];
					rd1_next = pinQ[3];
				end
				ppmr_pkg::RAMP_SER: begin
					ra0_next = serQ[1] & ~serQ[2];
					ra1_next = serQ[1] & serQ[2];
					rd0_next = serQ[3];
					rd1_next = serQ[3];
				end
				default: ;
			endcase
		end else begin
			unique case (rampAssign)
				ppmr_pkg::RAMP_OFF: begin
					if (modLevel == ppmr_pkg::LVL_SIXTEEN) begin
						if (pinMapSelect[1:0] == ppmr_pkg::PMAP_CH0LO)
							idx0_next = {pinQ[0], pinQ[1], pinQ[2], pinQ[3]};
						else if (pinMapSelect[1:0] == ppmr_pkg::PMAP_CH1LO)
							idx1_next = {pinQ[0], pinQ[1], pinQ[2], pinQ[3]};
						else
							err_next = 1'b1;
					end else
						err_next = 1'b1;
				end
				ppmr_pkg::RAMP_P23: begin
					if (modLevel == ppmr_pkg::LVL_TWO && pinMapSelect == ppmr_pkg::PMAP_DUAL) begin
						idx0_next = {3'h0, pinQ[0]};
						idx1_next = {3'h0, pinQ[1]};
						ra0_next  = 1'b1;
						ra1_next  = 1'b1;
						rd0_next  = pinQ[2];
						rd1_next  = pinQ[3];
					end else
						err_next = 1'b1;
				end
				ppmr_pkg::RAMP_P3: begin
					if (modLevel == ppmr_pkg::LVL_EIGHT
					    && pinMapSelect[1:0] == ppmr_pkg::PMAP_CH0LO) begin
						idx0_next = {1'b0, pinQ[0], pinQ[1], pinQ[2]};
						ra0_next  = 1'b1;
						rd0_next  = pinQ[3];
					end else if (modLevel == ppmr_pkg::LVL_EIGHT
					    && pinMapSelect[1:0] == ppmr_pkg::PMAP_CH1LO) begin
						idx1_next = {1'b0, pinQ[0], pinQ[1], pinQ[2]};
						ra1_next  = 1'b1;
						rd1_next  = pinQ[3];
					end else
						err_next = 1'b1;
				end
				ppmr_pkg::RAMP_SER: begin
					// serial line 1 triggers, 2 picks channel at two levels (at four levels line 1 triggers channel 0, line 2 channel 1), 3 picks direction
					if (link.dataWide)
						err_next = 1'b1;
					unique case (modLevel)
						ppmr_pkg::LVL_TWO: begin
							idx0_next = {3'h0, pinQ[2]};
							idx1_next = {3'h0, pinQ[3]};
							ra0_next  = serQ[1] & ~serQ[2];
							ra1_next  = serQ[1] & serQ[2];
							rd0_next  = serQ[3];
							rd1_next  = serQ[3];
						end
						ppmr_pkg::LVL_FOUR: begin
							if (pinMapSelect == ppmr_pkg::PMAP_DUAL) begin
								idx0_next = {2'h0, pinQ[0], pinQ[1]};
								idx1_next = {2'h0, pinQ[2], pinQ[3]};
								ra0_next  = serQ[1];
								ra1_next  = serQ[2];
								rd0_next  = serQ[3];
								rd1_next  = serQ[3];
							end else
								err_next = 1'b1;
						end
						ppmr_pkg::LVL_SIXTEEN: begin
							if (pinMapSelect[1:0] == ppmr_pkg::PMAP_CH0LO) begin
								idx0_next = {pinQ[0], pinQ[1], pinQ[2], pinQ[3]};
								ra0_next  = serQ[1];
								rd0_next  = serQ[3];
							end else if (pinMapSelect[1:0] == ppmr_pkg::PMAP_CH1LO) begin
								idx1_next = {pinQ[0], pinQ[1], pinQ[2], pinQ[3]};
								ra1_next  = serQ[1];
								rd1_next  = serQ[3];
							end else
								err_next = 1'b1;
						end
						default: err_next = 1'b1;
					endcase
				end
			endcase
		end
	end

	// routing outputs
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wordIndex0  <= ppmr_pkg::WORD_ZERO;
			wordIndex1  <= ppmr_pkg::WORD_ZERO;
			rampActive0 <= 1'b0;
			rampActive1 <= 1'b0;
			rampDown0   <= 1'b0;
			rampDown1   <= 1'b0;
			configError <= 1'b0;
		end else begin
			wordIndex0  <= idx0_next;
			wordIndex1  <= idx1_next;
			rampActive0 <= ra0_next;
			rampActive1 <= ra1_next;
			rampDown0   <= rd0_next;
			rampDown1   <= rd1_next;
			configError <= err_next;
		end
	end

	// sweep triggers: one-cycle pulses, input 0 for channel 0 and input 1 for channel 1
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sweepUp0   <= 1'b0;
			sweepUp1   <= 1'b0;
			sweepDown0 <= 1'b0;
			sweepDown1 <= 1'b0;
		end else begin
			sweepUp0   <= sweepEnable0 & pinRise[0];
			sweepDown0 <= sweepEnable0 & pinFall[0];
			sweepUp1   <= sweepEnable1 & pinRise[1];
			sweepDown1 <= sweepEnable1 & pinFall[1];
		end
	end

	function automatic logic [7:0] startAddr(input logic [1:0] tgt);
		unique case (tgt)
			ppmr_pkg::TGT_AMPL:  startAddr = ppmr_pkg::ADDR_AMPL0;
			ppmr_pkg::TGT_FREQ:  startAddr = ppmr_pkg::ADDR_FREQ0;
			ppmr_pkg::TGT_PHASE: startAddr = ppmr_pkg::ADDR_PHASE0;
			default:             startAddr = ppmr_pkg::ADDR_FREQ0;
		endcase
	endfunction

	// keep only the msb-aligned bits that the target uses
	function automatic logic [31:0] endMask(input logic [1:0] tgt, input logic [31:0] raw);
		unique case (tgt)
			ppmr_pkg::TGT_AMPL:  endMask = {raw[31 -: ppmr_pkg::AMPL_W], 22'h0};
			ppmr_pkg::TGT_PHASE: endMask = {raw[31 -: ppmr_pkg::PHASE_W], 18'h0};
			default:             endMask = raw;
		endcase
	endfunction

	// sweep word sources; target 00 leaves word zero at frequency address
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sweepStartAddr0 <= ppmr_pkg::ADDR_FREQ0;
			sweepStartAddr1 <= ppmr_pkg::ADDR_FREQ0;
			sweepEndAddr    <= ppmr_pkg::ADDR_WORD1;
			sweepEndWord0   <= 32'h0;
			sweepEndWord1   <= 32'h0;
		end else begin
			sweepStartAddr0 <= startAddr(sweepTargetSelect0);
			sweepStartAddr1 <= startAddr(sweepTargetSelect1);
			sweepEndAddr    <= ppmr_pkg::ADDR_WORD1;
			sweepEndWord0   <= endMask(sweepTargetSelect0, sweepEndRaw);
			sweepEndWord1   <= endMask(sweepTargetSelect1, sweepEndRaw);
		end
	end
endmodule

// *** hdl/ppmr_host.sv ***
// host end: drives profile inputs and serial ramp lines from user requests
// assumes device end samples the pins on core_clk
module ppmr_host (
	input  wire logic       core_clk,
	input  wire logic       reset,
	ppmr_link_if.host       link,
	input  wire logic [3:0] userProfile,
	input  wire logic       userRampReq,
	input  wire logic       userRampCh,
	input  wire logic       userRampDown,
	input  wire logic       userWide,
	input  wire logic [1:0] rampAssign,
	input  wire logic       sweepEnable0,
	input  wire logic       sweepEnable1,
	input  wire logic       sweepDir0,
	input  wire logic       sweepDir1,
	input  wire logic [1:0] modLevel,
	output logic            levelError
);
	logic serialRamp;
	assign serialRamp = (rampAssign == ppmr_pkg::RAMP_SER);

	// profile pins; sweep channels take inputs 0 and 1 as direction levels
	always_ff @(posedge core_clk) begin
		if (reset)
			link.profileIn <= 4'h0;
		else
			link.profileIn <= {userProfile[3:2],
			                   sweepEnable1 ? sweepDir1 : userProfile[1],
			                   sweepEnable0 ? sweepDir0 : userProfile[0]};
	end

	// serial lines carry trigger, channel and direction while ramping by serial
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link.serialOut <= 4'h0;
			link.serialOe  <= 4'h0;
			link.dataWide  <= 1'b0;
		end else begin
			link.serialOut <= {userRampDown, userRampCh, userRampReq, 1'b0};
			link.serialOe  <= serialRamp ? 4'he : 4'h0;
			link.dataWide  <= userWide & ~serialRamp;
		end
	end

	// flags sweep with a level other than two
	always_ff @(posedge core_clk) begin
		if (reset)
			levelError <= 1'b0;
		else
			levelError <= (sweepEnable0 | sweepEnable1)
			              & (modLevel != ppmr_pkg::LVL_TWO);
	end
endmodule

// *** bench/ppmr_chk.sv ***
// assertions on the link pins and routed device outputs
// assumes one core clock; placed beside the link by the bench
module ppmr_chk (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic [3:0] profileIn,
	input wire logic [3:0] serialOut,
	input wire logic [3:0] serialOe,
	input wire logic       dataWide,
	input wire logic [2:0] pinMapSelect,
	input wire logic [1:0] modLevel,
	input wire logic [1:0] rampAssign,
	input wire logic       sweepEnable0,
	input wire logic       sweepEnable1,
	input wire logic [3:0] wordIndex0,
	input wire logic [3:0] wordIndex1,
	input wire logic       rampActive0,
	input wire logic       rampActive1,
	input wire logic       rampDown0,
	input wire logic       rampDown1,
	input wire logic       sweepUp0,
	input wire logic [7:0] sweepEndAddr,
	input wire logic       configError
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] upCnt;
	logic [8:0] cfgQ;
	logic [3:0] pQ1, p, sQ1, s;
	wire  [8:0] cfg = {pinMapSelect, modLevel, rampAssign, sweepEnable0, sweepEnable1};
	wire  [3:0] m   = {modLevel, rampAssign};
	wire        ok  = upCnt == 2'h3 && cfg == cfgQ;
	wire        rt  = ok && !sweepEnable0 && !sweepEnable1;
	// settle count: stages still hold reset values just after release
	always_ff @(posedge core_clk) begin
		if (reset)
			upCnt <= 2'h0;
		else if (upCnt != 2'h3)
			upCnt <= upCnt + 2'h1;
	end
	// pins two edges back line up with the output stage
	always_ff @(posedge core_clk) begin
		{p, pQ1, s, sQ1, cfgQ} <= {pQ1, profileIn, sQ1, serialOut & serialOe, cfg};
	end
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (reset);
	sixteen_idx_a: assert property (rt && m == 4'hc && pinMapSelect[1:0] == 2'h2
		|-> wordIndex0 == {p[0], p[1], p[2], p[3]}) else $error("sixteen level index");
	dual_two_a: assert property (rt && m == 4'h1 && pinMapSelect == 3'h5 |->
		wordIndex0 == {3'h0, p[0]} && wordIndex1 == {3'h0, p[1]}
		&& rampDown0 == p[2] && rampDown1 == p[3]) else $error("dual two level route");
	eight_ramp_a: assert property (rt && m == 4'ha && pinMapSelect[1:0] == 2'h3 |->
		wordIndex1 == {1'h0, p[0], p[1], p[2]} && rampActive1 && rampDown1 == p[3])
		else $error("eight level ramp route");
	serial_eight_a: assert property (rt && m == 4'hb |-> configError)
		else $error("eight level serial accepted");
	wide_error_a: assert property (rampAssign == 2'h3 |=> !dataWide)
		else $error("wide transfer during serial ramp");
	two_serial_a: assert property (rt && m == 4'h3 && s[1] && !s[2] |->
		wordIndex0 == {3'h0, p[2]} && wordIndex1 == {3'h0, p[3]} && rampActive0
		&& rampDown0 == s[3]) else $error("two level serial route");
	four_serial_a: assert property (rt && m == 4'h7 && pinMapSelect == 3'h5 |->
		wordIndex0 == {2'h0, p[0], p[1]} && wordIndex1 == {2'h0, p[2], p[3]}
		&& rampActive1 == s[2]) else $error("four level serial route");
	sweep_edge_a: assert property (ok && sweepEnable0 && modLevel == 2'h0
		&& $rose(profileIn[0]) |-> ##[2:4] sweepUp0) else $error("no rising sweep");
	end_addr_a: assert property (sweepEndAddr == 8'h0a)
		else $error("sweep end address");
endmodule

// *** bench/testbench.sv ***
// self-checking bench: host and device ends joined by the link
// assumes a 50 ns core clock and synchronous active high reset
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [1:0] lv, ra;
		logic [2:0] pm;
		logic [3:0] pr;
		logic [2:0] sr;
		logic [3:0] w0, w1;
		logic [1:0] ac, dn;
		logic       er;
	} ppmr_row_t;
	logic        core_clk = 1'b0, reset = 1'b1;
	logic        userRampReq = 1'b0, userRampCh = 1'b0, userRampDown = 1'b0;
	logic        userWide = 1'b0, sweepEnable0 = 1'b0, sweepEnable1 = 1'b0;
	logic        sweepDir0 = 1'b0, sweepDir1 = 1'b0;
	logic [3:0]  userProfile = 4'h0;
	logic [2:0]  pinMapSelect = 3'h0;
	logic [1:0]  modLevel = 2'h0, rampAssign = 2'h0;
	logic [1:0]  sweepTargetSelect0 = 2'h0, sweepTargetSelect1 = 2'h0;
	logic [31:0] sweepEndRaw = 32'h89abcdef, sweepEndWord0, sweepEndWord1;
	logic [3:0]  wordIndex0, wordIndex1;
	logic [7:0]  sweepStartAddr0, sweepStartAddr1, sweepEndAddr;
	logic        rampActive0, rampActive1, rampDown0, rampDown1, configError, levelError;
	logic        sweepUp0, sweepUp1, sweepDown0, sweepDown1;
	int          bad_count = 0, checks = 0;
	// rows: level, ramp, map, pins, serial {dn,ch,req} -> indices, active, down, error
	ppmr_row_t rows[12] = '{
		'{2'h3, 2'h0, 3'h2, 4'hb, 3'h0, 4'hd, 4'h0, 2'h0, 2'h0, 1'h0},
		'{2'h3, 2'h0, 3'h3, 4'h7, 3'h0, 4'h0, 4'he, 2'h0, 2'h0, 1'h0},
		'{2'h0, 2'h1, 3'h5, 4'h5, 3'h0, 4'h1, 4'h0, 2'h3, 2'h1, 1'h0},
		'{2'h2, 2'h2, 3'h2, 4'he, 3'h0, 4'h3, 4'h0, 2'h1, 2'h1, 1'h0},
		'{2'h2, 2'h2, 3'h3, 4'h1, 3'h0, 4'h0, 4'h4, 2'h2, 2'h0, 1'h0},
		'{2'h2, 2'h3, 3'h2, 4'hf, 3'h0, 4'h0, 4'h0, 2'h0, 2'h0, 1'h1},
		'{2'h0, 2'h1, 3'h2, 4'h5, 3'h0, 4'h0, 4'h0, 2'h0, 2'h0, 1'h1},
		'{2'h0, 2'h3, 3'h0, 4'hb, 3'h7, 4'h0, 4'h1, 2'h2, 2'h2, 1'h0},
		'{2'h0, 2'h3, 3'h7, 4'h4, 3'h1, 4'h1, 4'h0, 2'h1, 2'h0, 1'h0},
		'{2'h1, 2'h3, 3'h5, 4'hb, 3'h7, 4'h3, 4'h1, 2'h3, 2'h3, 1'h0},
		'{2'h3, 2'h3, 3'h2, 4'hb, 3'h1, 4'hd, 4'h0, 2'h1, 2'h0, 1'h0},
		'{2'h3, 2'h3, 3'h3, 4'h7, 3'h5, 4'h0, 4'he, 2'h2, 2'h2, 1'h0}};
	ppmr_link_if link ();
	ppmr_host ppmr_host_i (.core_clk, .reset, .link, .userProfile, .userRampReq, .userRampCh,
		.userRampDown, .userWide, .rampAssign, .sweepEnable0, .sweepEnable1, .sweepDir0,
		.sweepDir1, .modLevel, .levelError);
	ppmr_device ppmr_device_i (.core_clk, .reset, .link, .pinMapSelect, .modLevel, .rampAssign,
		.sweepTargetSelect0, .sweepTargetSelect1, .sweepEnable0, .sweepEnable1, .sweepEndRaw,
		.wordIndex0, .wordIndex1, .rampActive0, .rampActive1, .rampDown0, .rampDown1, .sweepUp0,
		.sweepUp1, .sweepDown0, .sweepDown1, .sweepStartAddr0, .sweepStartAddr1, .sweepEndAddr,
		.sweepEndWord0, .sweepEndWord1, .configError);
	ppmr_chk ppmr_chk_i (.core_clk, .reset, .profileIn(link.profileIn),
		.serialOut(link.serialOut), .serialOe(link.serialOe), .dataWide(link.dataWide),
		.pinMapSelect, .modLevel, .rampAssign, .sweepEnable0, .sweepEnable1, .wordIndex0,
		.wordIndex1, .rampActive0, .rampActive1, .rampDown0, .rampDown1, .sweepUp0,
		.sweepEndAddr, .configError);
	// free-running core clock
	always #25 core_clk = ~core_clk;
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// pipeline is three edges deep, six leaves margin
	task automatic apply(input ppmr_row_t r);
		{modLevel, rampAssign, pinMapSelect, userProfile} = {r.lv, r.ra, r.pm, r.pr};
		{userRampDown, userRampCh, userRampReq} = r.sr;
		cyc(6);
		chk({wordIndex0, wordIndex1}, {r.w0, r.w1});
		chk({rampActive1, rampActive0}, r.ac);
		chk({rampDown1, rampDown0} & r.ac, r.dn);
		chk(configError, r.er);
	endtask
	// pulses are one cycle wide, so each is seen at exactly one falling edge
	task automatic pulses(output logic [15:0] n);
		n = 16'h0;
		repeat (8) begin
			@(negedge core_clk);
			n += {3'h0, sweepDown1, 3'h0, sweepDown0, 3'h0, sweepUp1, 3'h0, sweepUp0};
		end
	endtask
	// main sequence
	initial begin
		logic [15:0] n;
		cyc(2);
		chk({wordIndex0, sweepStartAddr0, sweepEndAddr}, {4'h0, 8'h04, 8'h0a});
		cyc(1);
		reset = 1'b0;
		foreach (rows[i]) apply(rows[i]);
		reset = 1'b1;
		cyc(2);
		chk({wordIndex1, rampActive1}, 5'h0);
		reset = 1'b0;
		{modLevel, rampAssign, userRampReq, userWide} = {2'h0, 2'h3, 1'h0, 1'h1};
		cyc(6);
		// the host must hold the link narrow, so the device never sees a wide request
		chk({link.dataWide, configError}, 2'h0);
		userWide = 1'b0;
		cyc(6);
		chk(configError, 1'h0);
		{rampAssign, sweepEnable0, sweepEnable1, sweepDir1} = {2'h0, 3'h7};
		for (int t = 1; t < 4; t++) begin
			sweepTargetSelect0 = t[1:0];
			sweepTargetSelect1 = 2'(t % 3 + 1);
			cyc(4);
			chk(sweepStartAddr0, t == 1 ? 8'h06 : t == 2 ? 8'h04 : 8'h05);
			chk(sweepStartAddr1, t == 1 ? 8'h04 : t == 2 ? 8'h05 : 8'h06);
			chk(sweepEndWord0, sweepEndRaw & (t == 1 ? 32'hffc00000 : t == 2 ? 32'hffffffff
				: 32'hfffc0000));
			chk(sweepEndWord1, sweepEndRaw & (t == 1 ? 32'hffffffff : t == 2 ? 32'hfffc0000
				: 32'hffc00000));
		end
		sweepDir0 = 1'b1;
		pulses(n);
		chk(n, 16'h0001);
		sweepDir1 = 1'b0;
		pulses(n);
		chk(n, 16'h1000);
		// channel 0 falls while channel 1 rises in the same cycle
		{sweepDir0, sweepDir1} = 2'h1;
		pulses(n);
		chk(n, 16'h0110);
		// ramp on inputs two and three while both channels sweep
		{rampAssign, userProfile} = {2'h1, 4'h4};
		cyc(4);
		chk({wordIndex0, wordIndex1, rampActive1, rampActive0, rampDown1, rampDown0}, 12'h00d);
		modLevel = 2'h1;
		cyc(4);
		chk({levelError, configError}, 2'h3);
		end_sim;
	end
	// watchdog: the sequence needs about 133 cycles
	initial begin
		#100us;
		bad_count++;
		end_sim;
	end
endmodule
